//--- hdl/wdt_map.svh
/*
 * register offsets, field positions, reset values and key words of the windowed watchdog.
 * assumes a 32-bit AXI4-Lite slave, one aligned word per register.
 */
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ==========================================================================
// register byte offsets
`define WDT_CTRL_OFF      8'h00
`define WDT_TOUT_OFF      8'h04
`define WDT_WINDOW_OFF    8'h08
`define WDT_INTVAL_OFF    8'h0c
`define WDT_SERVICE_OFF   8'h10
`define WDT_COUNT_OFF     8'h14
`define WDT_STATUS_OFF    8'h18
`define WDT_MASK_OFF      8'h1c

// ==========================================================================
// control fields
`define WDT_CTRL_EN       0
`define WDT_CTRL_WP       1
`define WDT_CTRL_STOP     2
`define WDT_CTRL_WAIT     3
`define WDT_CTRL_REFLOSS  4
`define WDT_CTRL_IE       5
`define WDT_CTRL_CLK_LO   6
`define WDT_CTRL_PS_LO    8
`define WDT_CTRL_W        10

// ==========================================================================
// status fields
`define WDT_ST_EARLY      0
`define WDT_ST_TIMEOUT    1
`define WDT_ST_W          2

// ==========================================================================
// reset values
`define WDT_CTRL_RST      10'h000
`define WDT_TOUT_RST      16'hffff
`define WDT_WINDOW_RST    16'hffff
`define WDT_INTVAL_RST    16'h00ff

// ==========================================================================
// service key words
`define WDT_KEY_FIRST     16'h5555
`define WDT_KEY_SECOND    16'haaaa

// ==========================================================================
// prescale terminal counts, each one less than its factor
`define WDT_DIV1          11'h000
`define WDT_DIV16         11'h00f
`define WDT_DIV256        11'h0ff
`define WDT_DIV1024       11'h3ff

`endif

//--- hdl/wdt_pkg.sv
/*
 * types of the windowed watchdog.
 * assumes wdt_map.svh is included where offsets are needed.
 */
package wdt_pkg;
	// ======================================================================
	// clock source select
	typedef enum logic [1:0] {
		WDT_SRC_RELAX   = 2'h0,
		WDT_SRC_CRYSTAL = 2'h1,
		WDT_SRC_BUS     = 2'h2,
		WDT_SRC_LOWOSC  = 2'h3
	} wdt_src_e;

	// ======================================================================
	// prescale select
	typedef enum logic [1:0] {
		WDT_PS_1    = 2'h0,
		WDT_PS_16   = 2'h1,
		WDT_PS_256  = 2'h2,
		WDT_PS_1024 = 2'h3
	} wdt_ps_e;

	// ======================================================================
	// service sequence state
	typedef enum logic [1:0] {
		WDT_SV_IDLE  = 2'b01,
		WDT_SV_ARMED = 2'b10
	} wdt_sv_e;
endpackage

//--- hdl/wdt_top.sv
/*
 * windowed watchdog: prescaled down-counter, two-word service, early interrupt,
 * reset output, write protection, AXI4-Lite register slave.
 * assumes source clock enables are synchronous one-cycle pulses in the aclk domain.
 */
`include "wdt_map.svh"

// Summary of operation
// - after write protect is set, control, interrupt, window, timeout writes are ignored.
// - counter counts down from timeout; reset output asserts at zero.
// - with interrupt enabled and the early mask bit set, reaching the interrupt value raises the interrupt.
// - a valid service reloads the counter with the current timeout.
// - service needs first key then second key, in that order.
// - counter clock selects relaxation, crystal, bus or low-speed oscillator.
// - selected source is divided by 1, 16, 256 or 1024.
// - counting and compares run in prescaled source ticks.
// - separate enables keep counting during stop and during wait.
// - loss-of-reference counter has its own enable bit.
// - timeout, window and interrupt values are 16-bit tick counts.
// - interrupt enable is writable only while write protection is off.
module wdt_top
	import wdt_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// clock source ticks
	input  wire logic        relaxation_osc_source,
	input  wire logic        crystal_osc_source,
	input  wire logic        lowspeed_osc_source,
	// system power modes
	input  wire logic        stop_mode,
	input  wire logic        wait_mode,
	// write address channel
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// write data channel
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// write response channel
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// read address channel
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// read data channel
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// outputs
	output logic             wdt_reset,
	output logic             irq,
	output logic             ref_loss_counter_enable
);
	// ======================================================================
	// registers
	logic [`WDT_CTRL_W-1:0] ctrl;
	logic [15:0]            timeout_value_reg;
	logic [15:0]            window_value_reg;
	logic [15:0]            early_irq_value_reg;
	logic [15:0]            count;
	logic [`WDT_ST_W-1:0]   status;
	logic [`WDT_ST_W-1:0]   mask;
	logic [10:0]            prescale_cnt;
	logic                   en_q;
	wdt_sv_e                sv_state;
	logic                   aw_held;
	logic                   w_held;
	logic [7:0]             aw_addr;
	logic [31:0]            w_data;

	wire logic wr_go = aw_held && w_held && !s_axi_bvalid;
	wire logic rd_go = s_axi_arvalid && !s_axi_rvalid;
	wire logic wp    = ctrl[`WDT_CTRL_WP];
	wire logic en    = ctrl[`WDT_CTRL_EN];

	function automatic logic [10:0] ps_limit(input logic [1:0] sel);
		case (sel)
			WDT_PS_1:    ps_limit = `WDT_DIV1;
			WDT_PS_16:   ps_limit = `WDT_DIV16;
			WDT_PS_256:  ps_limit = `WDT_DIV256;
			default:     ps_limit = `WDT_DIV1024;
		endcase
	endfunction

	function automatic logic wr_to(input logic [7:0] off);
		wr_to = wr_go && (aw_addr == off);
	endfunction

	// ======================================================================
	// write channels: address and data taken in either order
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_bresp   = 2'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ======================================================================
	// configuration writes; byte strobes ignored, whole-word registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl                <= `WDT_CTRL_RST;
			timeout_value_reg   <= `WDT_TOUT_RST;
			window_value_reg    <= `WDT_WINDOW_RST;
			early_irq_value_reg <= `WDT_INTVAL_RST;
			mask                <= {`WDT_ST_W{1'b0}};
		end else begin
			if (!wp) begin
				if (wr_to(`WDT_CTRL_OFF))
					ctrl <= w_data[`WDT_CTRL_W-1:0];
				if (wr_to(`WDT_TOUT_OFF))
					timeout_value_reg <= w_data[15:0];
				if (wr_to(`WDT_WINDOW_OFF))
					window_value_reg <= w_data[15:0];
				if (wr_to(`WDT_INTVAL_OFF))
					early_irq_value_reg <= w_data[15:0];
			end
			if (wr_to(`WDT_MASK_OFF))
				mask <= w_data[`WDT_ST_W-1:0];
		end
	end
	assign ref_loss_counter_enable = ctrl[`WDT_CTRL_REFLOSS];

	// ======================================================================
	// service sequence: any write to the service word other than the first key disarms
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sv_state <= WDT_SV_IDLE;
		end else if (wr_to(`WDT_SERVICE_OFF)) begin
			case (sv_state)
				WDT_SV_IDLE:
					sv_state <= (w_data[15:0] == `WDT_KEY_FIRST) ? WDT_SV_ARMED : WDT_SV_IDLE;
				WDT_SV_ARMED:
					sv_state <= (w_data[15:0] == `WDT_KEY_FIRST) ? WDT_SV_ARMED : WDT_SV_IDLE;
				default:
					sv_state <= WDT_SV_IDLE;
			endcase
		end
	end
	wire logic serviced = wr_to(`WDT_SERVICE_OFF) && sv_state == WDT_SV_ARMED
		&& w_data[15:0] == `WDT_KEY_SECOND;

	// ======================================================================
	// source select and prescaler
	logic src_tick;
	always_comb begin
		case (ctrl[`WDT_CTRL_CLK_LO +: 2])
			WDT_SRC_RELAX:   src_tick = relaxation_osc_source;
			WDT_SRC_CRYSTAL: src_tick = crystal_osc_source;
			WDT_SRC_BUS:     src_tick = 1'b1;
			default:         src_tick = lowspeed_osc_source;
		endcase
	end
	wire logic halted = (stop_mode && !ctrl[`WDT_CTRL_STOP])
		|| (wait_mode && !ctrl[`WDT_CTRL_WAIT]);
	wire logic run    = en && en_q && !halted && src_tick;
	wire logic tick   = run && prescale_cnt >= ps_limit(ctrl[`WDT_CTRL_PS_LO +: 2]);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			prescale_cnt <= 11'h000;
		else if (!en || serviced || tick)
			prescale_cnt <= 11'h000;
		else if (run)
			prescale_cnt <= prescale_cnt + 11'h001;
	end

	// ======================================================================
	// down-counter; reset output holds until a service or a disable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count     <= `WDT_TOUT_RST;
			en_q      <= 1'b0;
			wdt_reset <= 1'b0;
		end else begin
			en_q <= en;
			if ((en && !en_q) || serviced) begin
				count     <= timeout_value_reg;
				wdt_reset <= 1'b0;
			end else if (!en) begin
				wdt_reset <= 1'b0;
			end else if (tick && count != 16'h0000) begin
				count <= count - 16'h0001;
				if (count == 16'h0001)
					wdt_reset <= 1'b1;
			end else if (count == 16'h0000) begin
				wdt_reset <= 1'b1;
			end
		end
	end

	// ======================================================================
	// sticky events, cleared by a status read; a set wins over the clear
	wire logic early_hit = tick && ctrl[`WDT_CTRL_IE] && count != 16'h0000
		&& (count - 16'h0001) == early_irq_value_reg;
	wire logic to_hit    = tick && count == 16'h0001;
	wire logic st_rd     = rd_go && {s_axi_araddr[7:2], 2'b00} == `WDT_STATUS_OFF;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= {`WDT_ST_W{1'b0}};
			irq    <= 1'b0;
		end else begin
			status <= (st_rd ? {`WDT_ST_W{1'b0}} : status) | {to_hit, early_hit};
			// next mask as well, so a mask write leaves no stale cycle on the line
			irq    <= |(((st_rd ? {`WDT_ST_W{1'b0}} : status) | {to_hit, early_hit})
				& (wr_to(`WDT_MASK_OFF) ? w_data[`WDT_ST_W-1:0] : mask));
		end
	end

	// ======================================================================
	// read channel: one cycle after the address
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp   = 2'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			case ({s_axi_araddr[7:2], 2'b00})
				`WDT_CTRL_OFF:   s_axi_rdata <= {22'h0, ctrl};
				`WDT_TOUT_OFF:   s_axi_rdata <= {16'h0, timeout_value_reg};
				`WDT_WINDOW_OFF: s_axi_rdata <= {16'h0, window_value_reg};
				`WDT_INTVAL_OFF: s_axi_rdata <= {16'h0, early_irq_value_reg};
				`WDT_COUNT_OFF:  s_axi_rdata <= {16'h0, count};
				`WDT_STATUS_OFF: s_axi_rdata <= {30'h0, status};
				`WDT_MASK_OFF:   s_axi_rdata <= {30'h0, mask};
				default:         s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ======================================================================
	// checks
	sequence key_pair_s;
		wr_go && aw_addr == `WDT_SERVICE_OFF && sv_state == WDT_SV_ARMED
		&& w_data[15:0] == `WDT_KEY_SECOND;
	endsequence

	wp_blocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wp |=> $stable(timeout_value_reg) && $stable(ctrl))
		else $error("protected register changed");
	service_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
		key_pair_s |=> count == $past(timeout_value_reg))
		else $error("service did not reload");
	reset_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(en && en_q && count == 16'h0000 && !serviced) |=> wdt_reset)
		else $error("no reset at zero");
	early_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		early_hit |=> status[`WDT_ST_EARLY])
		else $error("early event lost");
	start_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(en && !en_q) |=> count == $past(timeout_value_reg))
		else $error("enable did not load");
	halt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(halted && en_q && en && !serviced) |=> $stable(count))
		else $error("counted while halted");
	protect_values_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wp |=> $stable(window_value_reg) && $stable(early_irq_value_reg))
		else $error("protected value changed");
	irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		irq == |(status & mask))
		else $error("interrupt line disagrees with status");
	reset_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(wdt_reset) |-> count == 16'h0000)
		else $error("reset output rose before zero");
	stray_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!(en && !en_q) && !(wr_go && aw_addr == `WDT_SERVICE_OFF && sv_state == WDT_SV_ARMED
		&& w_data[15:0] == `WDT_KEY_SECOND) |=> count <= $past(count))
		else $error("counter reloaded without key pair");
endmodule

//--- testbench/windowed_watchdog_timer_tb_top.sv
/* bench for wdt_top: register model, source and prescale timing, early irq, service keys,
   power modes and write protection. assumes wdt_map.svh and a 100 ns aclk. */
`include "wdt_map.svh"
module windowed_watchdog_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ======================================================================
	// signals
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [2:0]  osc = 0;
	logic [1:0]  modes = 0;
	logic [7:0]  awaddr = 0;
	logic [7:0]  araddr = 0;
	logic [31:0] wdata = 0;
	logic        awvalid = 0;
	logic        wvalid = 0;
	logic        bready = 0;
	logic        arvalid = 0;
	logic        rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, wdt_reset, irq, rl_en;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [31:0] mreg [8];
	logic [31:0] wmask [8] = '{32'h3ff, 32'hffff, 32'hffff, 32'hffff, 0, 0, 0, 32'h3};
	logic [31:0] seed = 32'd96620;
	int          fac [4] = '{1, 16, 256, 1024};
	int          n_mismatch = 0;
	int          checks_done = 0;
	wire logic [3:0] all_src = {osc[2], 1'b1, osc[1:0]};
	always #50 aclk = ~aclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// random source ticks keep the prescaler honest about counting pulses, not cycles
	always @(posedge aclk) begin
		osc <= 3'(rnd());
	end
	wdt_top DUT (.aclk(aclk), .aresetn(aresetn), .relaxation_osc_source(osc[0]),
		.crystal_osc_source(osc[1]), .lowspeed_osc_source(osc[2]), .stop_mode(modes[0]),
		.wait_mode(modes[1]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.wdt_reset(wdt_reset), .irq(irq), .ref_loss_counter_enable(rl_en));
	// ======================================================================
	// checking and bus tasks
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(inout int n);
		n++;
		if (n > 30000) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		logic ta = 0;
		logic tw = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(negedge aclk);
			tick(n);
			if (awvalid && awready) ta = 1;
			if (wvalid && wready) tw = 1;
			@(posedge aclk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
		end while (!(ta && tw));
		bready <= 1;
		do begin
			@(negedge aclk);
			tick(n);
		end while (!bvalid);
		chk(32'(bresp), 32'h0);
		@(posedge aclk);
		bready <= 0;
		// protected registers keep their value once the protect bit is set
		if (a[7:5] == 0 && wmask[a[4:2]] != 0 && !(mreg[0][1] && a < 8'h10))
			mreg[a[4:2]] = d & wmask[a[4:2]];
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		int n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(negedge aclk);
			tick(n);
		end while (!arready);
		@(posedge aclk);
		arvalid <= 0;
		do begin
			@(negedge aclk);
			tick(n);
		end while (!rvalid);
		d = rdata;
		chk(32'(rresp), 32'h0);
		@(posedge aclk);
		rready <= 0;
	endtask
	task automatic rchk(input logic [7:0] a);
		logic [31:0] d;
		rd(a, d);
		chk(d, mreg[a[4:2]]);
	endtask
	// ======================================================================
	// main sequence
	initial begin
		logic [31:0] d, d2;
		int n, p, t, ps;
		logic early;
		mreg = '{0, 32'hffff, 32'hffff, 32'hff, 0, 0, 0, 0};
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		for (int i = 0; i < 4; i++) rchk(8'(i * 4));
		wr(8'h24, 32'h5);
		rd(8'h24, d);
		chk(d, 0);
		wr(`WDT_MASK_OFF, 32'h3);
		rchk(`WDT_MASK_OFF);
		wr(`WDT_WINDOW_OFF, 32'hfffe);
		rchk(`WDT_WINDOW_OFF);
		for (int k = 0; k < 8; k++) begin
			ps = k / 2;
			// one tick of 16 or more pulses keeps expiry at least 16 bus cycles past the early point
			t = (k < 2) ? 60 : 6;
			wr(`WDT_TOUT_OFF, 32'(t));
			wr(`WDT_INTVAL_OFF, 32'h1);
			wr(`WDT_CTRL_OFF, 32'((ps << 8) | ((k % 4) << 6) | 32'h20));
			wr(`WDT_CTRL_OFF, 32'((ps << 8) | ((k % 4) << 6) | 32'h21));
			n = 0;
			p = 0;
			early = 0;
			do begin
				@(negedge aclk);
				tick(n);
				p += int'(all_src[k % 4]);
				if (irq) early = 1;
			end while (!wdt_reset);
			chk(32'(p >= (t - 1) * fac[ps] && p <= (t + 1) * fac[ps] + 4), 1);
			chk(32'(early), 1);
			rd(`WDT_STATUS_OFF, d);
			chk(d, 32'h3);
			rd(`WDT_STATUS_OFF, d);
			chk(d, 0);
			wr(`WDT_CTRL_OFF, 32'h0);
			repeat (2) @(negedge aclk);
			chk(32'(irq), 0);
			chk(32'(wdt_reset), 0);
		end
		wr(`WDT_TOUT_OFF, 32'd200);
		wr(`WDT_CTRL_OFF, 32'h81);
		repeat (50) @(posedge aclk);
		wr(`WDT_SERVICE_OFF, 32'h5555);
		wr(`WDT_SERVICE_OFF, 32'haaaa);
		rd(`WDT_COUNT_OFF, d);
		chk(32'(d >= 185 && d <= 200), 1);
		wr(`WDT_SERVICE_OFF, 32'haaaa);
		wr(`WDT_SERVICE_OFF, 32'h5555);
		wr(`WDT_SERVICE_OFF, (rnd() & 32'h0fff) | 32'h1000);
		wr(`WDT_SERVICE_OFF, 32'haaaa);
		rd(`WDT_COUNT_OFF, d2);
		chk(32'(d2 + 10 < d), 1);
		n = 0;
		do begin
			@(negedge aclk);
			tick(n);
		end while (!wdt_reset);
		chk(32'(irq), 1);
		rd(`WDT_STATUS_OFF, d);
		chk(d, 32'h2);
		wr(`WDT_TOUT_OFF, 32'd300);
		wr(`WDT_SERVICE_OFF, 32'h5555);
		wr(`WDT_SERVICE_OFF, 32'haaaa);
		rd(`WDT_COUNT_OFF, d);
		chk(32'(d >= 285 && d <= 300), 1);
		chk(32'(wdt_reset), 0);
		for (int m = 0; m < 2; m++) begin
			modes <= 2'(1 << m);
			rd(`WDT_COUNT_OFF, d);
			repeat (10) @(posedge aclk);
			rd(`WDT_COUNT_OFF, d2);
			chk(d2, d);
			wr(`WDT_CTRL_OFF, 32'h81 | (32'h4 << m));
			rd(`WDT_COUNT_OFF, d);
			repeat (10) @(posedge aclk);
			rd(`WDT_COUNT_OFF, d2);
			chk(32'(d2 < d), 1);
			modes <= 0;
			wr(`WDT_CTRL_OFF, 32'h81);
		end
		wr(`WDT_CTRL_OFF, 32'h90);
		repeat (2) @(negedge aclk);
		chk(32'(rl_en), 1);
		// the protect bit cannot be undone, so this comes last
		wr(`WDT_CTRL_OFF, 32'h02);
		rchk(`WDT_CTRL_OFF);
		chk(32'(rl_en), 0);
		wr(`WDT_CTRL_OFF, 32'h20);
		rchk(`WDT_CTRL_OFF);
		for (int i = 1; i < 4; i++) begin
			wr(8'(i * 4), 32'h7);
			rchk(8'(i * 4));
		end
		tally_and_finish();
	end
endmodule
